// *** hdl/leo_ladder_ops.sv ***
// Scan-driven one-shot contacts, latches, bit-of-word latches and output freeze
//
// How it works
// - Parallel falling one-shot closes one scan after its point falls.
// - Series rising one-shot ANDs rung with a one-scan rise pulse.
// - Series falling one-shot ANDs rung with a one-scan fall pulse.
// - Latch-on sets a point range for that scan only; the next scan reloads the image from rungImage.
// - Latch-off clears a point range for that scan only; the next scan reloads rungImage.
// - Timer and counter operands rejected by latch-on, accepted by latch-off.
// - Latch-on leaves points mapped to physical inputs untouched.
// - Word-bit latch-on sets bit 0..15 of a word until latch-off.
// - Word-bit latch-off clears the selected bit persistently.
// - Frozen outputs stop taking image values and are driven off.
// - Image keeps updating during freeze, frozen range included.
`timescale 1ns/1ps
`default_nettype none
module leo_ladder_ops #(
  parameter int unsigned POINTS = leo_pkg::POINT_COUNT
) (
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic                        scanTick,
  input  wire logic [POINTS-1:0]           rungImage,
  input  wire logic [POINTS-1:0]           inputMapped,
  input  wire logic [leo_pkg::INDEX_W-1:0] contactSel,
  input  wire logic                        rungIn,
  input  wire leo_pkg::leo_latch_type      latchReq,
  input  wire leo_pkg::leo_wbit_type       wbitReq,
  input  wire leo_pkg::leo_freeze_type     freezeReq,
  input  wire logic [POINTS-1:0]           freezeOverride,
  output logic                             orFallingOneShot,
  output logic                             andRisingOneShot,
  output logic                             andFallingOneShot,
  output logic [POINTS-1:0]                image,
  output logic [POINTS-1:0]                physOut,
  output logic [leo_pkg::WORD_W-1:0]       memWord [leo_pkg::WORD_COUNT],
  output logic                             latchRejected
);
  logic [POINTS-1:0] image_q;
  logic [POINTS-1:0] prevImage_q;
  logic [POINTS-1:0] physOut_q;
  logic [POINTS-1:0] range_d;
  logic [POINTS-1:0] freezeRange_d;
  logic [POINTS-1:0] setMask_d;
  logic              onAllowed_d;
  logic              curPt;
  logic              prevPt;
  logic              orFall_q;
  logic              andRise_q;
  logic              andFall_q;
  logic              reject_q;
  logic [leo_pkg::WORD_W-1:0] mem_q [leo_pkg::WORD_COUNT];

  function automatic logic [POINTS-1:0] rangeMask(
    input logic [leo_pkg::INDEX_W-1:0] lo,
    input logic [leo_pkg::INDEX_W-1:0] hi
  );
    logic [POINTS-1:0] m;
    m = '0;
    for (int i = 0; i < POINTS; i++) begin
      m[i] = (i >= int'(lo)) && (i <= int'(hi));
    end
    return m;
  endfunction

  assign range_d       = rangeMask(latchReq.first, latchReq.last);
  assign freezeRange_d = rangeMask(freezeReq.first, freezeReq.last);
  assign onAllowed_d   = latchReq.opnd == leo_pkg::OPND_POINT;
  assign setMask_d     = range_d & ~inputMapped;
  assign curPt         = image_q[contactSel];
  assign prevPt        = prevImage_q[contactSel];

  // Image register: latch ops act only on a scan with the rung true
  always_ff @(posedge clock) begin
    if (reset) begin
      image_q <= '0;
    end else if (scanTick) begin
      image_q <= rungImage;
      if (rungIn && latchReq.latchOn && onAllowed_d) begin
        image_q <= rungImage | setMask_d;
      end else if (rungIn && latchReq.latchOff) begin
        image_q <= rungImage & ~range_d;
      end
    end
  end

  // Previous-scan copy of the image for edge detection
  always_ff @(posedge clock) begin
    if (reset) begin
      prevImage_q <= '0;
    end else if (scanTick) begin
      prevImage_q <= image_q;
    end
  end

  // One-shot contacts, held for one scan
  always_ff @(posedge clock) begin
    if (reset) begin
      orFall_q  <= 1'b0;
      andRise_q <= 1'b0;
      andFall_q <= 1'b0;
    end else if (scanTick) begin
      orFall_q  <= prevPt && !curPt;
      andRise_q <= rungIn && !prevPt && curPt;
      andFall_q <= rungIn && prevPt && !curPt;
    end
  end

  // Latch-on attempted with a timer or counter operand
  always_ff @(posedge clock) begin
    if (reset) begin
      reject_q <= 1'b0;
    end else if (scanTick) begin
      reject_q <= rungIn && latchReq.latchOn && !onAllowed_d;
    end
  end

  // Bit-of-word memory
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int w = 0; w < leo_pkg::WORD_COUNT; w++) begin
        mem_q[w] <= '0;
      end
    end else if (scanTick && rungIn) begin
      if (wbitReq.wordBitLatchOn) begin
        mem_q[wbitReq.word][wbitReq.bitSel] <= 1'b1;
      end else if (wbitReq.wordBitLatchOff) begin
        mem_q[wbitReq.word][wbitReq.bitSel] <= 1'b0;
      end
    end
  end

  // Output transfer with freeze and per-point override
  always_ff @(posedge clock) begin
    if (reset) begin
      physOut_q <= '0;
    end else if (scanTick) begin
      if (freezeReq.freeze) begin
        physOut_q <= image_q & ~(freezeRange_d & ~freezeOverride);
      end else begin
        physOut_q <= image_q;
      end
    end
  end

  assign orFallingOneShot  = orFall_q;
  assign andRisingOneShot  = andRise_q;
  assign andFallingOneShot = andFall_q;
  assign image             = image_q;
  assign physOut           = physOut_q;
  assign memWord           = mem_q;
  assign latchRejected     = reject_q;

  AST_FALL_PULSE: assert property (@(posedge clock) disable iff (reset)
    scanTick && prevPt && !curPt |=> orFallingOneShot)
    else $error("falling one-shot missed");
  AST_RISE_AND: assert property (@(posedge clock) disable iff (reset)
    scanTick && !(rungIn && !prevPt && curPt) |=> !andRisingOneShot)
    else $error("rising one-shot closed without rise");
  AST_FALL_AND: assert property (@(posedge clock) disable iff (reset)
    scanTick && rungIn && prevPt && !curPt |=> andFallingOneShot)
    else $error("series falling one-shot missed");
  AST_LATCH_ON: assert property (@(posedge clock) disable iff (reset)
    scanTick && rungIn && latchReq.latchOn && onAllowed_d
    |=> (image & $past(setMask_d)) == $past(setMask_d))
    else $error("latch-on did not set range");
  AST_LATCH_OFF: assert property (@(posedge clock) disable iff (reset)
    scanTick && rungIn && latchReq.latchOff && !latchReq.latchOn
    |=> (image & $past(range_d)) == '0)
    else $error("latch-off did not clear range");
  AST_REJECT: assert property (@(posedge clock) disable iff (reset)
    scanTick && !onAllowed_d |=> image == $past(rungImage)
      || $past(!rungIn || !latchReq.latchOn))
    else $error("timer or counter latch-on took effect");
  AST_WBIT_ON: assert property (@(posedge clock) disable iff (reset)
    scanTick && rungIn && wbitReq.wordBitLatchOn
    |=> memWord[$past(wbitReq.word)][$past(wbitReq.bitSel)])
    else $error("word bit not set");
  AST_WBIT_OFF: assert property (@(posedge clock) disable iff (reset)
    scanTick && rungIn && wbitReq.wordBitLatchOff && !wbitReq.wordBitLatchOn
    |=> !memWord[$past(wbitReq.word)][$past(wbitReq.bitSel)])
    else $error("word bit not cleared");
  AST_FREEZE: assert property (@(posedge clock) disable iff (reset)
    scanTick && freezeReq.freeze
    |=> (physOut & $past(freezeRange_d & ~freezeOverride)) == '0)
    else $error("frozen output driven");
  AST_IMAGE_RUNS: assert property (@(posedge clock) disable iff (reset)
    scanTick && !rungIn |=> image == $past(rungImage))
    else $error("image stopped updating");
endmodule
`default_nettype wire

// *** hdl/leo_pkg.sv ***
// Shared constants and carriers for the ladder edge, latch and pause block
package leo_pkg;
  localparam int unsigned POINT_COUNT = 32'h0000_0040;
  localparam int unsigned INDEX_W     = 32'h0000_0006;
  localparam int unsigned WORD_W      = 32'h0000_0010;
  localparam int unsigned BIT_SEL_W   = 32'h0000_0004;
  localparam int unsigned WORD_COUNT  = 32'h0000_0004;
  localparam int unsigned WORD_SEL_W  = 32'h0000_0002;
  localparam logic [WORD_SEL_W-1:0] WORD_SEL_LAST = 2'h3;

  // Operand classes of a latch target
  typedef enum logic [1:0] {
    OPND_POINT,
    OPND_TIMER,
    OPND_COUNTER
  } leo_opnd_type;

  // Latch request over a point range
  typedef struct packed {
    logic                 latchOn;
    logic                 latchOff;
    leo_opnd_type         opnd;
    logic [INDEX_W-1:0]   first;
    logic [INDEX_W-1:0]   last;
  } leo_latch_type;

  // Bit-of-word request
  typedef struct packed {
    logic                  wordBitLatchOn;
    logic                  wordBitLatchOff;
    logic [WORD_SEL_W-1:0] word;
    logic [BIT_SEL_W-1:0]  bitSel;
  } leo_wbit_type;

  // Output freeze request
  typedef struct packed {
    logic               freeze;
    logic [INDEX_W-1:0] first;
    logic [INDEX_W-1:0] last;
  } leo_freeze_type;
endpackage

// *** test/leo_out_points.sv ***
// Model of the discrete output points and their override setting
`timescale 1ns/1ps
`default_nettype none
module leo_out_points (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [63:0] physOut,
  input  wire logic [63:0] cfgOverride,
  output logic      [63:0] freezeOverride,
  output logic      [63:0] points
);
  always_ff @(posedge clock) begin
    freezeOverride <= reset ? 64'h0000_0000_0000_0000 : cfgOverride;
  end
  always_ff @(posedge clock) begin
    points <= physOut;
  end
endmodule
`default_nettype wire

// *** test/leo_ladder_ops_test.sv ***
// Randomised scan bench for the ladder one-shot, latch and pause block
`timescale 1ns/1ps
`default_nettype none
module leo_ladder_ops_test;
  typedef struct packed {
    logic        o, r, f, rj;
    logic [63:0] img, phy, mw;
  } leo_exp_type;
  leo_exp_type             q [$];
  leo_exp_type             e, x;
  leo_pkg::leo_latch_type  latchReq = '0;
  leo_pkg::leo_wbit_type   wbitReq = '0;
  leo_pkg::leo_freeze_type freezeReq = '0;
  logic        clock = 0, reset = 1, scanTick = 0, rungIn = 0;
  logic [63:0] rungImage = '0, inputMapped = '0, cfgOverride = '0;
  logic [63:0] img = '0, prv = '0, mw = '0, lm, fm;
  logic [63:0] physOut, image, freezeOverride;
  logic [5:0]  contactSel = '0;
  logic [15:0] memWord [4];
  logic        oF, aR, aF, rej;
  int          errorCnt = 0, checksDone = 0, cyc = 0, seed = 32'h0000_a245;
  int          r;

  leo_ladder_ops leo_ladder_ops_i (.clock, .reset, .scanTick, .rungImage,
    .inputMapped, .contactSel, .rungIn, .latchReq, .wbitReq, .freezeReq,
    .freezeOverride, .orFallingOneShot(oF), .andRisingOneShot(aR),
    .andFallingOneShot(aF), .image, .physOut, .memWord,
    .latchRejected(rej));
  leo_out_points leo_out_points_i (.clock, .reset, .physOut, .cfgOverride,
    .freezeOverride, .points());

  initial begin
    forever #12.5 clock = ~clock;
  end

  task automatic cmp(input logic [63:0] a, b, input string m);
    checksDone++;
    if (a !== b) begin
      errorCnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, a, b);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", checksDone, errorCnt);
    if (errorCnt == 0 && checksDone > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Random stimulus for one scan; the expected result is queued
  task automatic scan();
    logic [31:0] a, b;
    a = $random(seed);
    b = $random(seed);
    rungIn = a[0];
    contactSel = a[7:2];
    rungImage = {$random(seed), $random(seed)};
    inputMapped = {$random(seed), $random(seed)} & {$random(seed), b};
    latchReq.latchOn = rungIn & a[8];
    latchReq.latchOff = rungIn & ~a[8] & a[9];
    latchReq.opnd = leo_pkg::leo_opnd_type'(a[11:10] == 2'h3 ? 2'h0 : a[11:10]);
    latchReq.first = a[17:12];
    latchReq.last = a[17:12] | {3'h0, a[20:18]};
    freezeReq.freeze = a[21];
    freezeReq.first = a[27:22];
    freezeReq.last = a[27:22] | {2'h0, a[31:28]};
    wbitReq.wordBitLatchOn = rungIn & b[0];
    wbitReq.wordBitLatchOff = rungIn & ~b[0] & b[1];
    wbitReq.word = b[3:2];
    wbitReq.bitSel = b[7:4];
    if (b[8]) cfgOverride = {$random(seed), $random(seed)};
    for (int i = 0; i < 64; i++) begin
      lm[i] = i >= latchReq.first && i <= latchReq.last;
      fm[i] = freezeReq.freeze && i >= freezeReq.first && i <= freezeReq.last;
    end
    e.o = prv[contactSel] & ~img[contactSel];
    e.r = rungIn & ~prv[contactSel] & img[contactSel];
    e.f = rungIn & prv[contactSel] & ~img[contactSel];
    e.rj = latchReq.latchOn && latchReq.opnd != leo_pkg::OPND_POINT;
    e.img = rungImage;
    if (latchReq.latchOn && !e.rj) e.img |= lm & ~inputMapped;
    if (latchReq.latchOff) e.img &= ~lm;
    e.phy = img & ~(fm & ~freezeOverride);
    if (wbitReq.wordBitLatchOn) mw[{wbitReq.word, wbitReq.bitSel}] = 1'b1;
    if (wbitReq.wordBitLatchOff) mw[{wbitReq.word, wbitReq.bitSel}] = 1'b0;
    e.mw = mw;
    q.push_back(e);
    prv = img;
    img = e.img;
  endtask

  // Results are checked 1 ns after each scan edge
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errorCnt++;
      finish_test();
    end
    if (!reset && scanTick) begin
      #1;
      x = q.pop_front();
      cmp(oF, x.o, "or falling");
      cmp(aR, x.r, "and rising");
      cmp(aF, x.f, "and falling");
      cmp(rej, x.rj, "rejected");
      cmp(image, x.img, "image");
      cmp(physOut, x.phy, "outputs");
      cmp({memWord[3], memWord[2], memWord[1], memWord[0]}, x.mw, "words");
    end
  end

  initial begin
    repeat (10) @(negedge clock);
    reset = 1'b0;
    repeat (2000) begin
      @(negedge clock);
      r = $random(seed);
      if (r[1:0] != 2'h0) scan();
      scanTick = r[1:0] != 2'h0;
    end
    @(negedge clock);
    scanTick = 1'b0;
    repeat (2) @(negedge clock);
    $display("Random scan test done");
    finish_test();
  end
endmodule
`default_nettype wire
